// ===== holdoff_pkg.sv
// Constants shared by the hold-off and communication-loss timer logic
package holdoff_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_LINK_CTRL  = 8'h20;
  localparam logic [7:0] IDX_HOLDOFF    = 8'h22;
  localparam logic [7:0] IDX_TIMEOUT    = 8'h23;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h29;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         CTRL_BAUD_LSB    = 0;
  localparam int         CTRL_TX_EN_BIT   = 2;
  localparam int         TO_LONG_LSB      = 0;
  localparam int         TO_SHORT_LSB     = 4;
  localparam int         ST_SHORT_BIT     = 0;
  localparam int         ST_LONG_BIT      = 1;
  localparam logic [7:0] CTRL_RESET       = 8'h05;
  localparam logic [7:0] HOLDOFF_RESET    = 8'h00;
  localparam logic [7:0] TIMEOUT_RESET    = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET   = 2'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = TICK_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int RATE_125K_BPS = 125000;
  localparam int RATE_250K_BPS = 250000;
  localparam int RATE_500K_BPS = 500000;
  localparam int RATE_1M_BPS   = 1000000;
  localparam logic [10:0] BIT_CYC_125K = 11'(1000000000 / (RATE_125K_BPS / 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] BIT_CYC_250K = 11'(1000000000 / (RATE_250K_BPS / 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] BIT_CYC_500K = 11'(1000000000 / (RATE_500K_BPS / 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] BIT_CYC_1M   = 11'(1000000000 / (RATE_1M_BPS / 1000) / CLK_PERIOD_PS);

  // Timeout lengths in 0.1 s ticks, index is the selector code; code 0 is off
  localparam logic [7:0][15:0] TO_TICKS = {16'h8CA0, 16'h4650, 16'h1770, 16'h0258,
                                           16'h0064, 16'h0014, 16'h0001, 16'h0000};

endpackage

// ===== timer_if.sv
// Link between the control block and one communication-loss timer
`timescale 1ns/1ps
interface timer_if;
  logic [2:0] sel;
  logic       restart;
  logic       tick;
  logic       expired;

  modport owner (output sel, output restart, output tick, input expired);
  modport timer (input sel, input restart, input tick, output expired);
endinterface

// ===== comm_loss_timer.sv
// One communication-loss timer counting 0.1 s ticks up to a selected interval
`timescale 1ns/1ps
module comm_loss_timer (
  input wire logic pclk,
  input wire logic presetn,
  timer_if.timer   tif
);

  logic [15:0] cnt_q;
  logic        done_q;
  logic        expired_q;
  wire  [15:0] limit = holdoff_pkg::TO_TICKS[tif.sel];
  wire         off   = (tif.sel == 3'h0);
  wire         hit   = tif.tick && !done_q && (cnt_q + 16'h0001 == limit);

  // ==========================================================================
  // Counter, fires once per silent interval
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 16'h0000;
      done_q    <= 1'b0;
      expired_q <= 1'b0;
    end else if (tif.restart || off) begin   // see [RL6]
      cnt_q     <= 16'h0000;
      done_q    <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= hit;                      // see [RL3]
      if (hit) begin
        done_q <= 1'b1;
      end
      if (tif.tick && !done_q) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign tif.expired = expired_q;

  a_timer_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    off |=> !expired_q) else $error("disabled timer fired"); // see [RL6]
  a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    tif.restart |=> cnt_q == 16'h0000 && !expired_q) else $error("restart ignored"); // see [RL6]
  a_timer_interval: assert property (@(posedge pclk) disable iff (!presetn)
    expired_q |-> $past(cnt_q) + 16'h0001 == limit) else $error("wrong interval"); // see [RL3]

endmodule

// ===== uart_holdoff_comm_timeout.sv
// Response hold-off and communication-loss timers with APB registers
// Functional notes
// [RL1] After a received stop bit, wait 0 to 255 bit periods before transmitting.
// [RL2] Short timeout expiry sets the short-timeout fault flag.
// [RL3] Short selector: off, 0.1s, 2s, 10s, 1min, 10min, 30min, 1hour.
// [RL4] Host never writes zero to reserved timeout bit; full writes put one there.
// [RL5] Long timeout expiry forces the device into shutdown.
// [RL6] Long selector zero disables; valid host traffic restarts both timers.
// [RL7] Bit period follows line rate: 125k, 250k, 500k, 1M bits per second.
// [RL8] With the response transmitter disabled, nothing is sent.
`timescale 1ns/1ps
module uart_holdoff_comm_timeout #(
  parameter int TICK_CYCLES = holdoff_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        rx_stop_done,
  input  wire logic        rx_frame_valid,
  input  wire logic        tx_request,
  output wire logic        tx_start,
  output wire logic        shutdown,
  output wire logic        irq
);

  // ==========================================================================
  // Register bus decode
  // ==========================================================================
  logic [7:0]  ctrl_q;
  logic [7:0]  response_holdoff_count_q;
  logic [7:0]  comm_loss_timeout_select_q;
  logic [1:0]  status_q;
  logic [1:0]  status_d;
  logic [1:0]  mask_q;
  logic [31:0] prdata_q;
  logic        slverr_q;

  wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire [7:0] idx      = paddr[9:2];
  wire       hit_ctrl = aligned && idx == holdoff_pkg::IDX_LINK_CTRL;
  wire       hit_hold = aligned && idx == holdoff_pkg::IDX_HOLDOFF;
  wire       hit_to   = aligned && idx == holdoff_pkg::IDX_TIMEOUT;
  wire       hit_st   = aligned && idx == holdoff_pkg::IDX_IRQ_STATUS;
  wire       hit_mask = aligned && idx == holdoff_pkg::IDX_IRQ_MASK;
  wire       mapped   = hit_ctrl | hit_hold | hit_to | hit_st | hit_mask;
  wire       setup    = psel && !penable;
  wire       wr       = psel && penable && pwrite && mapped;
  wire [31:0] rd_mux  = hit_ctrl ? {24'h000000, ctrl_q} :
                        hit_hold ? {24'h000000, response_holdoff_count_q} :
                        hit_to   ? {24'h000000, comm_loss_timeout_select_q} :
                        hit_st   ? {30'h00000000, status_q} :
                        hit_mask ? {30'h00000000, mask_q} : 32'h00000000;

  // Read data and error are captured in the setup cycle so the access ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      slverr_q <= !mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && slverr_q;

  // Reserved timeout bit is stored as written; keeping it one is the host's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q                     <= holdoff_pkg::CTRL_RESET;
      response_holdoff_count_q   <= holdoff_pkg::HOLDOFF_RESET;
      comm_loss_timeout_select_q <= holdoff_pkg::TIMEOUT_RESET;
      mask_q                     <= holdoff_pkg::IRQ_MASK_RESET;
    end else if (wr) begin
      if (hit_ctrl) ctrl_q <= pwdata[7:0];
      if (hit_hold) response_holdoff_count_q <= pwdata[7:0];
      if (hit_to)   comm_loss_timeout_select_q <= pwdata[7:0]; // see [RL4]
      if (hit_mask) mask_q <= pwdata[1:0];
    end
  end

  // ==========================================================================
  // Bit period and response hold-off
  // ==========================================================================
  wire [1:0]  baud       = ctrl_q[holdoff_pkg::CTRL_BAUD_LSB +: 2];
  wire        tx_en      = ctrl_q[holdoff_pkg::CTRL_TX_EN_BIT];
  wire [10:0] bit_cycles = (baud == 2'b00) ? holdoff_pkg::BIT_CYC_125K :  // see [RL7]
                           (baud == 2'b01) ? holdoff_pkg::BIT_CYC_250K :
                           (baud == 2'b10) ? holdoff_pkg::BIT_CYC_500K :
                                             holdoff_pkg::BIT_CYC_1M;

  logic [10:0] bit_cnt_q;
  logic [7:0]  bits_left_q;
  logic        holding_q;
  logic        pending_q;
  wire         bit_end = holding_q && (bit_cnt_q == bit_cycles - 11'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_q   <= 11'h000;
      bits_left_q <= 8'h00;
      holding_q   <= 1'b0;
    end else if (rx_stop_done) begin
      bit_cnt_q   <= 11'h000;
      bits_left_q <= response_holdoff_count_q;                // see [RL1]
      holding_q   <= (response_holdoff_count_q != 8'h00);
    end else if (bit_end) begin
      bit_cnt_q   <= 11'h000;
      bits_left_q <= bits_left_q - 8'h01;
      holding_q   <= (bits_left_q != 8'h01);
    end else if (holding_q) begin
      bit_cnt_q <= bit_cnt_q + 11'h001;
    end
  end

  // A response held back while the transmitter is off is dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
    end else if (!tx_en) begin
      pending_q <= 1'b0;                                      // see [RL8]
    end else if (tx_request) begin
      pending_q <= 1'b1;
    end else if (tx_start) begin
      pending_q <= 1'b0;
    end
  end

  assign tx_start = tx_en && pending_q && !holding_q && !rx_stop_done; // see [RL1] see [RL8]

  // ==========================================================================
  // Communication-loss timers
  // ==========================================================================
  logic [31:0] pre_q;
  logic        tick_q;
  logic        shutdown_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 32'(TICK_CYCLES - 1));
      pre_q  <= (pre_q == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : pre_q + 32'h00000001;
    end
  end

  timer_if short_if ();
  timer_if long_if ();
  assign short_if.sel     = comm_loss_timeout_select_q[holdoff_pkg::TO_SHORT_LSB +: 3]; // see [RL3]
  assign long_if.sel      = comm_loss_timeout_select_q[holdoff_pkg::TO_LONG_LSB +: 3];  // see [RL6]
  assign short_if.restart = rx_frame_valid;                                             // see [RL6]
  assign long_if.restart  = rx_frame_valid;
  assign short_if.tick    = tick_q;
  assign long_if.tick     = tick_q;

  comm_loss_timer u_short (.pclk(pclk), .presetn(presetn), .tif(short_if));
  comm_loss_timer u_long  (.pclk(pclk), .presetn(presetn), .tif(long_if));

  // Shutdown holds until reset; nothing on this side can wake the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_q <= 1'b0;
    end else if (long_if.expired) begin
      shutdown_q <= 1'b1;                                     // see [RL5]
    end
  end

  assign shutdown = shutdown_q;

  // ==========================================================================
  // Fault flags and interrupt
  // ==========================================================================
  wire [1:0] st_events = {long_if.expired, short_if.expired};
  wire [1:0] st_clear  = (wr && hit_st) ? pwdata[1:0] : 2'b00;

  // A new event wins over a write-one-to-clear in the same cycle
  always_comb begin
    status_d = (status_q & ~st_clear) | st_events;           // see [RL2]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 2'b00;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_tx_quiet_off: assert property (@(posedge pclk) disable iff (!presetn) // see [RL8]
    !tx_en |-> !tx_start) else $error("transmit while disabled");
  a_tx_holdoff_wait: assert property (@(posedge pclk) disable iff (!presetn) // see [RL1]
    holding_q |-> !tx_start) else $error("transmit during hold-off");
  a_holdoff_starts: assert property (@(posedge pclk) disable iff (!presetn) // see [RL1]
    rx_stop_done && response_holdoff_count_q != 8'h00 |=> holding_q [*8])
    else $error("hold-off too short");
  a_holdoff_zero: assert property (@(posedge pclk) disable iff (!presetn) // see [RL1]
    rx_stop_done && response_holdoff_count_q == 8'h00 |=> !holding_q)
    else $error("zero hold-off delayed");
  a_bit_period: assert property (@(posedge pclk) disable iff (!presetn) // see [RL7]
    baud == 2'b11 |-> bit_cycles == holdoff_pkg::BIT_CYC_1M)
    else $error("bit period wrong");
  a_short_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // see [RL2]
    short_if.expired |=> status_q[holdoff_pkg::ST_SHORT_BIT]) else $error("short flag lost");
  a_long_shutdown: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
    long_if.expired |=> shutdown_q ##1 shutdown_q) else $error("no shutdown");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_q[0]) && mask_q[0] |-> irq) else $error("irq missing");

endmodule

// ===== host_uart_model.sv
// Behavioural host UART that marks received-frame events toward the block
`timescale 1ns/1ps
module host_uart_model (
  input  wire logic pclk,
  output logic      rx_stop_done,
  output logic      rx_frame_valid,
  output logic      tx_request
);
  initial begin
    rx_stop_done   = 1'h0;
    rx_frame_valid = 1'h0;
    tx_request     = 1'h0;
  end

  // ==========================================================================
  // One frame: stop bit seen, valid traffic only if good, a reply optionally asked
  // ==========================================================================
  // Pulses last exactly one cycle, so the block never sees a frame twice
  task automatic send(input logic ask, input logic good);
    @(posedge pclk);
    rx_stop_done   <= 1'h1;
    rx_frame_valid <= good;
    tx_request     <= ask;
    @(posedge pclk);
    rx_stop_done   <= 1'h0;
    rx_frame_valid <= 1'h0;
    tx_request     <= 1'h0;
  endtask
endmodule

// ===== uart_holdoff_comm_timeout_tb.sv
// Self-checking bench for the response hold-off and communication-loss timers
`timescale 1ns/1ps
module uart_holdoff_comm_timeout_tb;
  localparam int          T      = 10;
  localparam logic [11:0] A_CTRL = {2'h0, holdoff_pkg::IDX_LINK_CTRL, 2'h0};
  localparam logic [11:0] A_HOLD = {2'h0, holdoff_pkg::IDX_HOLDOFF, 2'h0};
  localparam logic [11:0] A_TO   = {2'h0, holdoff_pkg::IDX_TIMEOUT, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, holdoff_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_MASK = {2'h0, holdoff_pkg::IDX_IRQ_MASK, 2'h0};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        rx_stop_done, rx_frame_valid, tx_request, tx_start, shutdown, irq;
  logic [11:0] ra[4] = '{A_HOLD, A_TO, A_STAT, A_MASK};
  int          n_errors, compares, n;
  int          cyc = 0;
  int          tk[5] = '{0, 1, 20, 100, 600};
  int          bc[4] = '{1600, 800, 400, 200};

  uart_holdoff_comm_timeout #(.TICK_CYCLES(T)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_stop_done(rx_stop_done),
    .rx_frame_valid(rx_frame_valid), .tx_request(tx_request), .tx_start(tx_start),
    .shutdown(shutdown), .irq(irq));
  host_uart_model host (.pclk(pclk), .rx_stop_done(rx_stop_done),
    .rx_frame_valid(rx_frame_valid), .tx_request(tx_request));

  initial pclk = 1'h0;
  always #2.5 pclk = ~pclk;

  // ==========================================================================
  // Checking, bus access and closing
  // ==========================================================================
  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at an edge; data taken there
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'h0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  // Cycles from the edge that took the stop bit until tx_start shows
  task automatic wait_tx(input int lo, input int hi);
    n = 0;
    #1;
    while (tx_start !== 1'h1 && n < hi + 5) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
    n_errors = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1 check({27'h0, tx_start, shutdown, irq, pslverr, pready}, 32'h1);
    rd(A_CTRL);
    check(rd_q, {24'h0, holdoff_pkg::CTRL_RESET});
    foreach (ra[i]) begin
      rd(ra[i]);
      check(rd_q, 32'h0);
    end
    rd(12'h0FC);
    check({rd_q[30:0], err_q}, 32'h1);
    rd(12'h089);
    check(32'(err_q), 32'h1);
    wr(A_HOLD, 32'h000000A5);
    rd(A_HOLD);
    check(rd_q, 32'h000000A5);
    for (int b = 0; b < 4; b++) begin
      wr(A_CTRL, 32'(4 + b));
      wr(A_HOLD, 32'h2);
      host.send(1'h1, 1'h1);
      wait_tx(2 * bc[b] - 1, 2 * bc[b] + 1);
    end
    wr(A_HOLD, 32'h0);
    host.send(1'h1, 1'h1);
    wait_tx(0, 1);
    wr(A_HOLD, 32'hFF);
    host.send(1'h1, 1'h1);
    wait_tx(255 * 200 - 1, 255 * 200 + 1);
    // Zero hold-off, so only the disabled transmitter keeps the line quiet
    wr(A_HOLD, 32'h0);
    wr(A_CTRL, 32'h3);
    host.send(1'h1, 1'h1);
    repeat (20) begin
      @(posedge pclk);
      #1 check(32'(tx_start), 32'h0);
    end
    wr(A_CTRL, 32'h7);
    // The refused request must not come out once the transmitter is back on
    repeat (4) begin
      @(posedge pclk);
      #1 check(32'(tx_start), 32'h0);
    end
    wr(A_MASK, 32'h3);
    // Reserved timeout bit always written as one by this host
    for (int c = 0; c < 5; c++) begin
      wr(A_TO, 32'(c * 16 + 8));
      wr(A_STAT, 32'h3);
      host.send(1'h0, 1'h1);
      if (c > 1) begin
        repeat ((tk[c] - 1) * T - 6) @(posedge pclk);
        rd(A_STAT);
        check(rd_q, 32'h0);
      end
      repeat (2 * T + 6) @(posedge pclk);
      rd(A_STAT);
      check(rd_q, 32'(c != 0));
      check({30'h0, irq, shutdown}, {30'h0, c != 0, 1'h0});
    end
    wr(A_MASK, 32'h0);
    #1 check(32'(irq), 32'h0);
    wr(A_MASK, 32'h1);
    #1 check(32'(irq), 32'h1);
    wr(A_STAT, 32'h1);
    #1 check(32'(irq), 32'h0);
    wr(A_TO, 32'h28);
    wr(A_STAT, 32'h3);
    repeat (4) begin
      host.send(1'h0, 1'h1);
      repeat (150) @(posedge pclk);
    end
    rd(A_STAT);
    check(rd_q, 32'h0);
    // Frames that end without valid traffic must not restart the timers
    repeat (2) begin
      host.send(1'h0, 1'h0);
      repeat (150) @(posedge pclk);
    end
    rd(A_STAT);
    check(rd_q, 32'h1);
    wr(A_TO, 32'h09);
    wr(A_STAT, 32'h3);
    host.send(1'h0, 1'h1);
    repeat (2 * T + 6) @(posedge pclk);
    #1 check(32'(shutdown), 32'h1);
    rd(A_STAT);
    check(rd_q, 32'h2);
    // Shutdown is sticky through traffic and leaves only with a reset
    host.send(1'h0, 1'h1);
    #1 check(32'(shutdown), 32'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    #1 check({30'h0, shutdown, irq}, 32'h0);
    rd(A_TO);
    check(rd_q, {24'h0, holdoff_pkg::TIMEOUT_RESET});
    results();
  end
endmodule
